// *** verilog/ocm_pkg.sv ***
// shared constants and types of the clock-source fault monitor
// assumes a single system clock; every consumer imports the whole package
package ocm_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_MHZ    = 100;
    localparam int unsigned OSC_SETTLE_MS   = 200;
    // settle time in system clock cycles, 20,000,000 at 100 MHz
    localparam int unsigned OSC_SETTLE_CYC  = OSC_SETTLE_MS * 1000 * CLK_FREQ_MHZ;

    // ------------------------------------------------------------
    // global clock status layout
    // ------------------------------------------------------------
    localparam int unsigned STAT_W          = 16;
    localparam int unsigned OSCILLATOR_FAILURE_FLAG_BIT    = 0;
    localparam int unsigned PLL_SLIP_BIT    = 8;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic        OSC_EN_RST      = 1'b1;
    localparam logic        PLL_EN_RST      = 1'b0;

    // ------------------------------------------------------------
    // peripheral clock divider widths
    // ------------------------------------------------------------
    localparam int unsigned DIV_W           = 4;

    // fault-detection startup phases
    typedef enum logic {
        OCM_ST_SETTLE,
        OCM_ST_MONITOR
    } ocm_mon_state_t;

endpackage

// *** verilog/ocm_clk_if.sv ***
// carrier between the monitor top and its peripheral clock aligner
// assumes both ends sit on the same system clock
`timescale 1ns/1ps

interface ocm_clk_if;
    import ocm_pkg::*;

    // ratio settings and the aligned tick strobes
    logic [DIV_W-1:0] sec_div;
    logic [DIV_W-1:0] per_mult;
    logic             sec_tick;
    logic             per_tick;

    modport ctrl (
        output sec_div,
        output per_mult,
        input  sec_tick,
        input  per_tick
    );

    modport gen (
        input  sec_div,
        input  per_mult,
        output sec_tick,
        output per_tick
    );
endinterface

// *** verilog/ocm_clk_align.sv ***
// peripheral clock aligner: secondary and peripheral ticks from one counter chain
// assumes settings are static while in use; a change restarts both clocks together
`timescale 1ns/1ps

module ocm_clk_align
    import ocm_pkg::*;
(
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // ratio settings in, ticks out
    ocm_clk_if.gen    clk_if
);

    // ------------------------------------------------------------
    // counter chain
    // ------------------------------------------------------------
    logic [DIV_W-1:0]   sec_cnt_q,  sec_cnt_d;
    logic [DIV_W-1:0]   per_cnt_q,  per_cnt_d;
    logic [2*DIV_W-1:0] cfg_q,      cfg_d;
    logic               sec_tick_q, sec_tick_d;
    logic               per_tick_q, per_tick_d;
    logic               restart;
    logic               sec_wrap;

    assign cfg_d   = {clk_if.sec_div, clk_if.per_mult};
    assign restart = (cfg_d != cfg_q);

    // peripheral tick only ever fires on a secondary tick, so edges coincide
    always_comb begin
        sec_wrap   = (sec_cnt_q == clk_if.sec_div);
        sec_cnt_d  = sec_wrap ? '0 : sec_cnt_q + 1'b1;
        per_cnt_d  = per_cnt_q;
        sec_tick_d = sec_wrap;
        per_tick_d = sec_wrap && (per_cnt_q == clk_if.per_mult);
        if (sec_wrap) begin
            per_cnt_d = (per_cnt_q == clk_if.per_mult) ? '0 : per_cnt_q + 1'b1;
        end
        // realign from a common origin rather than drift into a new phase
        if (restart) begin
            sec_cnt_d  = '0;
            per_cnt_d  = '0;
            sec_tick_d = 1'b0;
            per_tick_d = 1'b0;
        end
    end

    // reset puts both counters at the same origin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt_q  <= '0;
            per_cnt_q  <= '0;
            cfg_q      <= '0;
            sec_tick_q <= 1'b0;
            per_tick_q <= 1'b0;
        end else begin
            sec_cnt_q  <= sec_cnt_d;
            per_cnt_q  <= per_cnt_d;
            cfg_q      <= cfg_d;
            sec_tick_q <= sec_tick_d;
            per_tick_q <= per_tick_d;
        end
    end

    assign clk_if.sec_tick = sec_tick_q;
    assign clk_if.per_tick = per_tick_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_edge_aligned;
        per_tick_q |-> sec_tick_q;
    endproperty
    a_edge_aligned: assert property (p_edge_aligned) else $error("peripheral tick without secondary tick");

    property p_restart_quiet;
        restart |=> (!sec_tick_q && !per_tick_q && sec_cnt_q == '0 && per_cnt_q == '0);
    endproperty
    a_restart_quiet: assert property (p_restart_quiet) else $error("aligner did not restart");

endmodule

// *** verilog/osc_pll_fault_clock_monitor.sv ***
// clock-source supervision: oscillator fault, pll slip, fallback switching,
// disable protection and aligned peripheral clock ticks
// assumes fault inputs are synchronous levels and request inputs are one-cycle pulses
`timescale 1ns/1ps

// Overview of operation
// - after reset, wait the oscillator settle time before watching for oscillator faults
// - an oscillator fault sets the sticky oscillator failure flag, status bit 0
// - oscillator fault moves source 0 and source 1 onto the fallback oscillator
// - oscillator fault raises an error if enabled, and a reset if configured
// - a pll slip sets the sticky pll slip flag, status bit 8
// - a pll slip moves source 1 off the pll until cleared
// - a pll slip raises an error if enabled, and a reset if configured
// - pll output reaches no domain until software clears both the slip and oscillator failure flags
// - a disable request for a source in use, including by the pll, is rejected
// - a stable pll feeding a domain keeps the oscillator from being disabled
// - peripheral clock edges coincide with secondary clock edges, also after reset
module osc_pll_fault_clock_monitor
    import ocm_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = OSC_SETTLE_CYC
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    // fault detectors
    input  wire logic                 osc_fault_raw,
    input  wire logic                 pll_slip_raw,
    input  wire logic                 pll_stable,
    // software flag clears, one-cycle pulses
    input  wire logic                 oscillator_failure_flag_clear,
    input  wire logic                 pll_slip_clear,
    // response controls
    input  wire logic                 err_enable,
    input  wire logic                 reset_on_oscillator_failure_flag,
    input  wire logic                 reset_on_slip,
    // source enable and disable requests, one-cycle pulses
    input  wire logic                 osc_enable_req,
    input  wire logic                 osc_disable_req,
    input  wire logic                 pll_enable_req,
    input  wire logic                 pll_disable_req,
    // source usage by clock domains
    input  wire logic                 dom_uses_osc,
    input  wire logic                 dom_uses_pll,
    // peripheral clock ratio settings
    input  wire logic [DIV_W-1:0]     sec_div,
    input  wire logic [DIV_W-1:0]     per_mult,
    // status
    output logic      [STAT_W-1:0]    global_clock_status,
    output logic                      monitor_active,
    output logic                      osc_enabled,
    output logic                      pll_enabled,
    output logic                      disable_rejected,
    // clock routing
    output logic                      src0_on_fallback,
    output logic                      src1_on_fallback,
    output logic                      pll_to_domains,
    // responses to the error signalling module and reset logic
    output logic                      error_signal,
    output logic                      reset_request,
    // aligned peripheral clock ticks
    output logic                      sec_tick,
    output logic                      per_tick
);

    // ------------------------------------------------------------
    // oscillator settle window
    // ------------------------------------------------------------
    localparam logic [31:0] SETTLE_LAST = 32'(SETTLE_CYCLES - 1);

    ocm_mon_state_t state_q, state_d;
    logic [31:0]    cnt_q,   cnt_d;
    logic           mon_active;

    // a fault seen during settling is a young oscillator, not a failure
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            OCM_ST_SETTLE: begin
                if (cnt_q == SETTLE_LAST) begin
                    state_d = OCM_ST_MONITOR;
                end else begin
                    cnt_d = cnt_q + 32'h0000_0001;
                end
            end
            OCM_ST_MONITOR: begin
                state_d = OCM_ST_MONITOR;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= OCM_ST_SETTLE;
            cnt_q   <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign mon_active = (state_q == OCM_ST_MONITOR);

    // ------------------------------------------------------------
    // sticky fault flags and responses
    // ------------------------------------------------------------
    logic osc_flag_q,  osc_flag_d;
    logic slip_flag_q, slip_flag_d;
    logic err_q,       err_d;
    logic rst_req_q,   rst_req_d;
    logic src0_fb_q,   src0_fb_d;
    logic src1_fb_q,   src1_fb_d;
    logic pll_out_q,   pll_out_d;
    logic osc_rise;
    logic slip_rise;
    // enable state sits here because the pll gate below already reads it
    logic osc_en_q,    osc_en_d;
    logic pll_en_q,    pll_en_d;
    logic rej_q,       rej_d;
    logic osc_in_use;

    // set wins over a clear in the same cycle so no fault is lost
    always_comb begin
        osc_flag_d  = (osc_flag_q & ~oscillator_failure_flag_clear) | (mon_active & osc_fault_raw);
        slip_flag_d = (slip_flag_q & ~pll_slip_clear) | pll_slip_raw;
        osc_rise    = osc_flag_d & ~osc_flag_q;
        slip_rise   = slip_flag_d & ~slip_flag_q;
        err_d       = err_enable & (osc_rise | slip_rise);
        rst_req_d   = (reset_on_oscillator_failure_flag & osc_rise) | (reset_on_slip & slip_rise);
        // blocking follows the flags, so only a clear releases it
        src0_fb_d   = osc_flag_d;
        src1_fb_d   = osc_flag_d | slip_flag_d;
        // restart alone is not enough; both flags must be cleared first
        pll_out_d   = pll_en_q & pll_stable & ~slip_flag_d & ~osc_flag_d;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_flag_q  <= 1'b0;
            slip_flag_q <= 1'b0;
            err_q       <= 1'b0;
            rst_req_q   <= 1'b0;
            src0_fb_q   <= 1'b0;
            src1_fb_q   <= 1'b0;
            pll_out_q   <= 1'b0;
        end else begin
            osc_flag_q  <= osc_flag_d;
            slip_flag_q <= slip_flag_d;
            err_q       <= err_d;
            rst_req_q   <= rst_req_d;
            src0_fb_q   <= src0_fb_d;
            src1_fb_q   <= src1_fb_d;
            pll_out_q   <= pll_out_d;
        end
    end

    // ------------------------------------------------------------
    // source enables with in-use protection
    // ------------------------------------------------------------
    // the pll depends on the oscillator, so an enabled pll counts as a user
    always_comb begin
        osc_in_use = dom_uses_osc | pll_en_q | (pll_stable & dom_uses_pll);
        osc_en_d   = osc_en_q;
        pll_en_d   = pll_en_q;
        rej_d      = 1'b0;
        if (osc_enable_req) begin
            osc_en_d = 1'b1;
        end else if (osc_disable_req) begin
            if (osc_in_use) begin
                rej_d = 1'b1;
            end else begin
                osc_en_d = 1'b0;
            end
        end
        if (pll_enable_req) begin
            pll_en_d = 1'b1;
        end else if (pll_disable_req) begin
            if (dom_uses_pll) begin
                rej_d = 1'b1;
            end else begin
                pll_en_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            osc_en_q <= OSC_EN_RST;
            pll_en_q <= PLL_EN_RST;
            rej_q    <= 1'b0;
        end else begin
            osc_en_q <= osc_en_d;
            pll_en_q <= pll_en_d;
            rej_q    <= rej_d;
        end
    end

    // ------------------------------------------------------------
    // peripheral clock alignment
    // ------------------------------------------------------------
    ocm_clk_if u_clk_if ();

    assign u_clk_if.sec_div  = sec_div;
    assign u_clk_if.per_mult = per_mult;

    ocm_clk_align u_align (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_if (u_clk_if.gen)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        global_clock_status               = '0;
        global_clock_status[OSCILLATOR_FAILURE_FLAG_BIT] = osc_flag_q;
        global_clock_status[PLL_SLIP_BIT] = slip_flag_q;
    end

    assign monitor_active   = mon_active;
    assign osc_enabled      = osc_en_q;
    assign pll_enabled      = pll_en_q;
    assign disable_rejected = rej_q;
    assign src0_on_fallback = src0_fb_q;
    assign src1_on_fallback = src1_fb_q;
    assign pll_to_domains   = pll_out_q;
    assign error_signal     = err_q;
    assign reset_request    = rst_req_q;
    assign sec_tick         = u_clk_if.sec_tick;
    assign per_tick         = u_clk_if.per_tick;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_settle_quiet;
        !mon_active |=> !$rose(osc_flag_q);
    endproperty
    a_settle_quiet: assert property (p_settle_quiet) else $error("oscillator flag set while settling");

    property p_settle_ends;
        (state_q == OCM_ST_SETTLE && cnt_q == SETTLE_LAST) |=> mon_active;
    endproperty
    a_settle_ends: assert property (p_settle_ends) else $error("monitoring did not start");

    property p_osc_set;
        (mon_active && osc_fault_raw) |=> (global_clock_status[OSCILLATOR_FAILURE_FLAG_BIT] && src0_on_fallback && src1_on_fallback);
    endproperty
    a_osc_set: assert property (p_osc_set) else $error("oscillator fault not handled");

    property p_sticky;
        (osc_flag_q && !oscillator_failure_flag_clear) |=> (osc_flag_q && src0_on_fallback);
    endproperty
    a_sticky: assert property (p_sticky) else $error("oscillator flag or block dropped");

    property p_slip_set;
        pll_slip_raw |=> (global_clock_status[PLL_SLIP_BIT] && src1_on_fallback && !pll_to_domains);
    endproperty
    a_slip_set: assert property (p_slip_set) else $error("pll slip not handled");

    sequence s_fault_rise;
        ($rose(osc_flag_q) || $rose(slip_flag_q)) && $past(err_enable);
    endsequence
    property p_error_out;
        s_fault_rise |-> error_signal ##1 !error_signal || $rose(osc_flag_q) || $rose(slip_flag_q);
    endproperty
    a_error_out: assert property (p_error_out) else $error("missing error pulse");

    property p_reset_slip;
        ($rose(slip_flag_q) && $past(reset_on_slip)) |-> reset_request;
    endproperty
    a_reset_slip: assert property (p_reset_slip) else $error("missing reset on slip");

    property p_pll_gate;
        (slip_flag_q || osc_flag_q) |-> !pll_to_domains;
    endproperty
    a_pll_gate: assert property (p_pll_gate) else $error("pll reached domains while flagged");

    sequence s_osc_reject;
        osc_disable_req && !osc_enable_req && osc_in_use;
    endsequence
    property p_osc_reject;
        s_osc_reject |=> (!$fell(osc_enabled) && disable_rejected);
    endproperty
    a_osc_reject: assert property (p_osc_reject) else $error("in-use oscillator was disabled");

    property p_pll_keeps_osc;
        (pll_stable && dom_uses_pll && osc_enabled) |=> osc_enabled;
    endproperty
    a_pll_keeps_osc: assert property (p_pll_keeps_osc) else $error("oscillator disabled under stable pll");

endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the clock-source fault monitor: settle, faults,
// clears, disable protection and aligned peripheral ticks
// assumes ocm_pkg and the monitor top are compiled before this file
`timescale 1ns/1ps

module tb_top;
    import ocm_pkg::*;

    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    localparam int unsigned SETTLE   = 16;
    localparam logic [5:0]  OSC_CLR  = 6'h01;
    localparam logic [5:0]  SLIP_CLR = 6'h02;
    localparam logic [5:0]  OSC_ON   = 6'h04;
    localparam logic [5:0]  OSC_OFF  = 6'h08;
    localparam logic [5:0]  PLL_ON   = 6'h10;
    localparam logic [5:0]  PLL_OFF  = 6'h20;

    logic              clock;
    logic              rst_n;
    logic              osc_fault_raw;
    logic              pll_slip_raw;
    logic              pll_stable;
    logic              err_enable;
    logic              reset_on_oscillator_failure_flag;
    logic              reset_on_slip;
    logic              dom_uses_osc;
    logic              dom_uses_pll;
    logic [5:0]        req;
    logic [DIV_W-1:0]  sec_div;
    logic [DIV_W-1:0]  per_mult;
    logic [STAT_W-1:0] global_clock_status;
    logic              monitor_active;
    logic              osc_enabled;
    logic              pll_enabled;
    logic              disable_rejected;
    logic              src0_on_fallback;
    logic              src1_on_fallback;
    logic              pll_to_domains;
    logic              error_signal;
    logic              reset_request;
    logic              sec_tick;
    logic              per_tick;
    int                error_cnt;
    int                n_checks;

    // short settle count keeps the run small
    osc_pll_fault_clock_monitor #(.SETTLE_CYCLES(SETTLE)) DUT (
        .clock(clock), .rst_n(rst_n), .osc_fault_raw(osc_fault_raw), .pll_slip_raw(pll_slip_raw),
        .pll_stable(pll_stable), .oscillator_failure_flag_clear(req[0]), .pll_slip_clear(req[1]),
        .err_enable(err_enable), .reset_on_oscillator_failure_flag(reset_on_oscillator_failure_flag), .reset_on_slip(reset_on_slip),
        .osc_enable_req(req[2]), .osc_disable_req(req[3]), .pll_enable_req(req[4]),
        .pll_disable_req(req[5]), .dom_uses_osc(dom_uses_osc), .dom_uses_pll(dom_uses_pll),
        .sec_div(sec_div), .per_mult(per_mult), .global_clock_status(global_clock_status),
        .monitor_active(monitor_active), .osc_enabled(osc_enabled), .pll_enabled(pll_enabled),
        .disable_rejected(disable_rejected), .src0_on_fallback(src0_on_fallback),
        .src1_on_fallback(src1_on_fallback), .pll_to_domains(pll_to_domains),
        .error_signal(error_signal), .reset_request(reset_request), .sec_tick(sec_tick),
        .per_tick(per_tick)
    );

    // ------------------------------------------------------------
    // clock, helpers and closing
    // ------------------------------------------------------------
    // 100 MHz system clock
    always #5 clock = ~clock;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // waits n edges, then lets their updates settle
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // one-cycle request pulse; returns with the answer edge settled
    task automatic pulse(input logic [5:0] m);
        @(posedge clock);
        req <= m;
        @(posedge clock);
        req <= 6'h00;
        #1;
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #50000;
        error_cnt++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        int cnt;
        int bad;
        int ns;
        int np;
        int fs;
        int fp;
        clock = 1'b0; rst_n = 1'b0; osc_fault_raw = 1'b1; pll_slip_raw = 1'b0; pll_stable = 1'b0;
        err_enable = 1'b1; reset_on_oscillator_failure_flag = 1'b1; reset_on_slip = 1'b0; dom_uses_osc = 1'b0;
        dom_uses_pll = 1'b0; req = 6'h00; sec_div = 4'h0; per_mult = 4'h2;
        error_cnt = 0; n_checks = 0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        // fault held high from power-up must be ignored while settling
        cnt = 0; bad = 0;
        while (monitor_active !== 1'b1 && cnt < SETTLE + 8) begin
            cyc(1);
            cnt++;
            if (global_clock_status[OSCILLATOR_FAILURE_FLAG_BIT] !== 1'b0) bad++;
        end
        chk(32'(cnt >= SETTLE - 1 && cnt <= SETTLE + 2), 32'h1);
        chk(32'(bad), 32'h0);
        cyc(1);
        chk(32'(global_clock_status), 32'h0001);
        chk(32'({src0_on_fallback, src1_on_fallback, pll_to_domains}), 32'h6);
        chk(32'({error_signal, reset_request}), 32'h3);
        cyc(1);
        chk(32'({error_signal, reset_request}), 32'h0);
        pulse(OSC_CLR);
        chk(32'(global_clock_status), 32'h0001);
        @(posedge clock);
        osc_fault_raw <= 1'b0;
        pulse(OSC_CLR);
        chk(32'(global_clock_status), 32'h0000);
        chk(32'({src0_on_fallback, src1_on_fallback}), 32'h0);
        $display("test osc fault done");

        // pll slip with and without error and reset responses
        @(posedge clock);
        pll_stable <= 1'b1;
        dom_uses_pll <= 1'b1;
        pulse(PLL_ON);
        chk(32'(pll_enabled), 32'h1);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            err_enable <= k[0];
            reset_on_slip <= k[0];
            cyc(2);
            chk(32'(pll_to_domains), 32'h1);
            @(posedge clock);
            pll_slip_raw <= 1'b1;
            cyc(1);
            chk(32'(global_clock_status), 32'h0100);
            chk(32'({src0_on_fallback, src1_on_fallback, pll_to_domains}), 32'h2);
            chk(32'({error_signal, reset_request}), 32'({k[0], k[0]}));
            @(posedge clock);
            pll_slip_raw <= 1'b0;
            cyc(4);
            chk(32'({global_clock_status[PLL_SLIP_BIT], src1_on_fallback, pll_to_domains}), 32'h6);
            pulse(SLIP_CLR);
            chk(32'(global_clock_status), 32'h0000);
        end
        $display("test pll slip done");

        // disable requests against sources in use
        pulse(PLL_OFF);
        chk(32'({disable_rejected, pll_enabled}), 32'h3);
        cyc(1);
        chk(32'(disable_rejected), 32'h0);
        pulse(OSC_OFF);
        chk(32'({disable_rejected, osc_enabled}), 32'h3);
        @(posedge clock);
        dom_uses_pll <= 1'b0;
        pulse(PLL_OFF);
        chk(32'({disable_rejected, pll_enabled}), 32'h0);
        // pll off but stable and named by a domain: only that term guards the oscillator
        @(posedge clock);
        dom_uses_pll <= 1'b1;
        pulse(OSC_OFF);
        chk(32'({disable_rejected, osc_enabled}), 32'h3);
        @(posedge clock);
        dom_uses_pll <= 1'b0;
        dom_uses_osc <= 1'b1;
        pulse(OSC_OFF);
        chk(32'({disable_rejected, osc_enabled}), 32'h3);
        @(posedge clock);
        dom_uses_osc <= 1'b0;
        pulse(OSC_OFF);
        chk(32'({disable_rejected, osc_enabled}), 32'h0);
        pulse(OSC_ON);
        chk(32'(osc_enabled), 32'h1);
        $display("test disable protection done");

        // tick ratio over a whole number of peripheral periods
        ns = 0; np = 0; bad = 0;
        for (int i = 0; i < 60; i++) begin
            cyc(1);
            if (sec_tick === 1'b1) ns++;
            if (per_tick === 1'b1) np++;
            if (per_tick === 1'b1 && sec_tick !== 1'b1) bad++;
        end
        chk(32'(bad), 32'h0);
        chk(32'(ns), 32'(60 / (sec_div + 1)));
        chk(32'(np), 32'(60 / ((sec_div + 1) * (per_mult + 1))));
        // mid-run reset: values return and alignment is rebuilt
        @(posedge clock);
        rst_n <= 1'b0;
        cyc(2);
        chk(32'({global_clock_status, osc_enabled, pll_enabled, monitor_active}), 32'h4);
        @(posedge clock);
        rst_n <= 1'b1;
        fs = 0; fp = 0; bad = 0;
        for (int i = 1; i <= 24; i++) begin
            cyc(1);
            if (sec_tick === 1'b1 && fs == 0) fs = i;
            if (per_tick === 1'b1 && fp == 0) fp = i;
            if (per_tick === 1'b1 && sec_tick !== 1'b1) bad++;
        end
        chk(32'(fs >= 1 && fs <= sec_div + 2), 32'h1);
        chk(32'(fp - fs), 32'(per_mult * (sec_div + 1)));
        chk(32'(bad), 32'h0);
        $display("test peripheral ticks done");
        print_verdict();
    end
endmodule
